/* File: hw/dscg_pkg.sv */
// Constants and carrier types shared by the system clock generation block.
package dscg_pkg;
   // Host serial bus framing.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FRAME_BITS = ADDR_W + DATA_W;
   // Register addresses on the host serial bus.
   localparam logic [7:0] ADDR_GEN_RESET = 8'h01;
   localparam logic [7:0] ADDR_AUX_A_PLL = 8'hAB;
   localparam logic [7:0] ADDR_AUX_A_REF = 8'hAC;
   localparam logic [7:0] ADDR_AUX_B_PLL = 8'hAD;
   localparam logic [7:0] ADDR_AUX_B_REF = 8'hAE;
   // Field layout of the divider word.
   localparam int PLL_NDIV_LSB = 0;
   localparam int PLL_NDIV_W = 11;
   localparam int PLL_ODIV_LSB = 11;
   localparam int PLL_ODIV_W = 5;
   // Field layout of the reference word.
   localparam int REF_RDIV_LSB = 0;
   localparam int REF_RDIV_W = 12;
   localparam int REF_SEL_BIT = 14;
   localparam int REF_EN_BIT = 15;
   localparam logic [15:0] AUX_PLL_RESET = 16'h0000;
   localparam logic [15:0] AUX_REF_RESET = 16'h0000;
   // Oscillator limits and default source, in kHz.
   localparam int CLOCK_KHZ = 100000;
   localparam int XTAL_MAX_KHZ = 12288;
   localparam int EXT_MAX_KHZ = 24576;
   localparam int OSC_DFLT_KHZ = 19200;
   localparam int MAIN_KHZ = 24576;
   // Default dividers suited to the default oscillator.
   localparam logic [7:0] MAIN_MUL_DFLT = 8'h20;
   localparam logic [7:0] MAIN_DIV_DFLT = 8'h19;
   localparam logic [7:0] CONV_DIV_DFLT = 8'h03;
   localparam int TIMER_LATENCY_US = 250;
   localparam int TIMER_DIV_DFLT = TIMER_LATENCY_US * OSC_DFLT_KHZ / 1000;
   localparam int PEND_W = 16;

   typedef struct packed {
      logic [7:0] mainMul;
      logic [7:0] mainDiv;
      logic [7:0] convDiv;
      logic [15:0] timerDiv;
   } dscg_clk_param_t;

   typedef struct packed {
      logic en;
      logic refSel;
      logic [REF_RDIV_W-1:0] refDiv;
      logic [PLL_NDIV_W-1:0] nDiv;
      logic [PLL_ODIV_W-1:0] oDiv;
   } dscg_aux_cfg_t;
endpackage

/* File: hw/dscg_aux_clock.sv */
// One auxiliary system clock generator: reference divider, rate loop, output divider.
`timescale 1ns/100ps
`default_nettype none
module dscg_aux_clock
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic oscTick,
   input wire logic mainTick,
   input wire dscg_pkg::dscg_aux_cfg_t cfg,
   output logic clkOut
);
   logic [dscg_pkg::REF_RDIV_W-1:0] refCnt_reg, refCnt_next;
   logic [dscg_pkg::PEND_W-1:0] pend_reg, pend_next;
   logic [dscg_pkg::PLL_ODIV_W-1:0] outCnt_reg, outCnt_next;
   logic clkOut_reg, clkOut_next;
   logic refTick, compTick, vcoTick;
   logic [dscg_pkg::REF_RDIV_W-1:0] refLast;
   logic [dscg_pkg::PLL_ODIV_W-1:0] oEff;
   logic [dscg_pkg::PEND_W:0] pendSum;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      refTick = cfg.refSel ? mainTick : oscTick;
      refLast = (cfg.refDiv == '0) ? '0 : cfg.refDiv - 1'b1;
      oEff = (cfg.oDiv < 5'h02) ? 5'h02 : cfg.oDiv;
      compTick = 1'b0;
      refCnt_next = refCnt_reg;
      pend_next = pend_reg;
      outCnt_next = outCnt_reg;
      vcoTick = cfg.en && (pend_reg != '0);
      pendSum = {1'b0, pend_reg};
      if (!cfg.en)
      begin
         refCnt_next = '0;
         pend_next = '0;
         outCnt_next = '0;
      end
      else
      begin
         if (refTick)
         begin
            if (refCnt_reg >= refLast)
            begin
               refCnt_next = '0;
               compTick = 1'b1;
            end
            else
               refCnt_next = refCnt_reg + 1'b1;
         end
         // Each comparison edge owes N output-rate edges; they are paid
         // out one per cycle, so the average rate is ref / R * N.
         pendSum = {1'b0, pend_reg} - {16'h0000, vcoTick};
         if (compTick)
            pendSum = pendSum + {6'h00, cfg.nDiv};
         // Saturation drops edges rather than wrapping when N is too large.
         pend_next = pendSum[dscg_pkg::PEND_W] ? '1 :
                     pendSum[dscg_pkg::PEND_W-1:0];
         if (vcoTick)
            outCnt_next = (outCnt_reg >= oEff - 1'b1) ? '0 :
                          outCnt_reg + 1'b1;
      end
      clkOut_next = cfg.en && (outCnt_next >= (oEff >> 1));
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         refCnt_reg <= '0;
         pend_reg <= '0;
         outCnt_reg <= '0;
         clkOut_reg <= 1'b0;
      end
      else if (ce)
      begin
         refCnt_reg <= refCnt_next;
         pend_reg <= pend_next;
         outCnt_reg <= outCnt_next;
         clkOut_reg <= clkOut_next;
      end
   end

   assign clkOut = clkOut_reg;

   ////////////////////////////////////////////////////////////////////////////
   property p_auxOffWhenSaved;
      @(posedge clock) disable iff (!arst_n || !ce)
      !cfg.en |=> !clkOut_reg;
   endproperty
   a_auxOffWhenSaved: assert property (p_auxOffWhenSaved)
      else $error("aux clock runs while powersaved");

   property p_edgeOnlyOnVco;
      @(posedge clock) disable iff (!arst_n || !ce)
      ##1 $changed(clkOut_reg) |-> $past(vcoTick) || !$past(cfg.en)
         || $past(cfg.en, 2) != $past(cfg.en)
         || $past(cfg.oDiv, 2) != $past(cfg.oDiv);
   endproperty
   a_edgeOnlyOnVco: assert property (p_edgeOnlyOnVco)
      else $error("aux clock edge without a loop edge");
endmodule
`default_nettype wire

/* File: hw/dscg_top.sv */
// System clock generation: main clock, derived ticks, two auxiliary clocks.
`timescale 1ns/100ps
`default_nettype none
module dscg_top
#(
   parameter int TIMER_DIV = dscg_pkg::TIMER_DIV_DFLT
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic oscIn,
   input wire logic busSelect_n,
   input wire logic busClock,
   input wire logic busData,
   input wire logic idleMode,
   input wire logic clkParamLoad,
   input wire dscg_pkg::dscg_clk_param_t clkParamIn,
   output logic mainClockTick,
   output logic convClockTick,
   output logic timerTick,
   output logic auxClockOutA,
   output logic auxClockOutB
);
   typedef enum logic [1:0] {
      DSCG_IDLE = 2'b00,
      DSCG_ADDR = 2'b01,
      DSCG_DATA = 2'b11,
      DSCG_SKIP = 2'b10
   } dscg_state_t;

   // The sampling clock must see every level of the fastest oscillator.
   initial
   begin
      if (dscg_pkg::EXT_MAX_KHZ * 4 > dscg_pkg::CLOCK_KHZ)
         $error("oscillator too fast for the sampling clock");
      if (TIMER_DIV < 2 || TIMER_DIV > 65535)
         $error("TIMER_DIV out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: oscillator, select, serial clock, serial data.
   logic [3:0] pinMeta_reg, pinSync_reg;
   logic oscPrev_reg, busClkPrev_reg;
   logic oscTick, busRise, selected;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pinMeta_reg <= 4'h2;
         pinSync_reg <= 4'h2;
         oscPrev_reg <= 1'b0;
         busClkPrev_reg <= 1'b0;
      end
      else if (ce)
      begin
         pinMeta_reg <= {busData, busClock, busSelect_n, oscIn};
         pinSync_reg <= pinMeta_reg;
         oscPrev_reg <= pinSync_reg[0];
         busClkPrev_reg <= pinSync_reg[2];
      end
   end

   always_comb
   begin
      oscTick = pinSync_reg[0] && !oscPrev_reg;
      busRise = pinSync_reg[2] && !busClkPrev_reg;
      selected = !pinSync_reg[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock parameters, main clock loop and derived dividers.
   dscg_pkg::dscg_clk_param_t param_reg, param_next;
   logic [11:0] mainAcc_reg, mainAcc_next;
   logic [7:0] convCnt_reg, convCnt_next;
   logic [15:0] timerCnt_reg, timerCnt_next;
   logic mainTick_reg, mainTick_next, conv_reg, conv_next;
   logic timer_reg, timer_next;
   logic [11:0] accSum;

   always_comb
   begin
      param_next = clkParamLoad ? clkParamIn : param_reg;
      accSum = mainAcc_reg + (oscTick ? {4'h0, param_reg.mainMul} : 12'h000);
      mainTick_next = accSum >= {4'h0, param_reg.mainDiv};
      mainAcc_next = mainTick_next ? accSum - {4'h0, param_reg.mainDiv} :
                     accSum;
      conv_next = 1'b0;
      convCnt_next = convCnt_reg;
      if (mainTick_reg)
      begin
         conv_next = convCnt_reg + 1'b1 >= param_reg.convDiv;
         convCnt_next = conv_next ? 8'h00 : convCnt_reg + 1'b1;
      end
      timer_next = 1'b0;
      timerCnt_next = timerCnt_reg;
      if (oscTick)
      begin
         timer_next = timerCnt_reg + 1'b1 >= param_reg.timerDiv;
         timerCnt_next = timer_next ? 16'h0000 : timerCnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         param_reg <= {dscg_pkg::MAIN_MUL_DFLT, dscg_pkg::MAIN_DIV_DFLT,
                       dscg_pkg::CONV_DIV_DFLT, 16'(TIMER_DIV)};
         mainAcc_reg <= '0;
         convCnt_reg <= '0;
         timerCnt_reg <= '0;
         mainTick_reg <= 1'b0;
         conv_reg <= 1'b0;
         timer_reg <= 1'b0;
      end
      else if (ce)
      begin
         param_reg <= param_next;
         mainAcc_reg <= mainAcc_next;
         convCnt_reg <= convCnt_next;
         timerCnt_reg <= timerCnt_next;
         mainTick_reg <= mainTick_next;
         conv_reg <= conv_next;
         timer_reg <= timer_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host serial bus: 8 address bits then 16 data bits, MSB first.
   dscg_state_t state_reg, state_next;
   logic [4:0] bitCnt_reg, bitCnt_next;
   logic [23:0] shift_reg, shift_next;
   logic pendValid_reg, pendValid_next;
   logic [23:0] pend_reg, pend_next;
   logic [15:0] pllA_reg, pllA_next, refA_reg, refA_next;
   logic [15:0] pllB_reg, pllB_next, refB_reg, refB_next;
   logic apply, isAux;

   always_comb
   begin
      state_next = state_reg;
      bitCnt_next = bitCnt_reg;
      shift_next = shift_reg;
      pend_next = pend_reg;
      pendValid_next = pendValid_reg;
      isAux = shift_next[7:0] inside {dscg_pkg::ADDR_AUX_A_PLL,
         dscg_pkg::ADDR_AUX_A_REF, dscg_pkg::ADDR_AUX_B_PLL,
         dscg_pkg::ADDR_AUX_B_REF};
      // Writes wait for a timer tick in idle, which is the bus latency.
      apply = pendValid_reg && (!idleMode || timer_reg);
      if (apply)
         pendValid_next = 1'b0;
      if (!selected)
      begin
         state_next = DSCG_IDLE;
         bitCnt_next = '0;
      end
      else if (busRise)
      begin
         shift_next = {shift_reg[22:0], pinSync_reg[3]};
         bitCnt_next = bitCnt_reg + 1'b1;
         isAux = shift_next[7:0] inside {dscg_pkg::ADDR_AUX_A_PLL,
            dscg_pkg::ADDR_AUX_A_REF, dscg_pkg::ADDR_AUX_B_PLL,
            dscg_pkg::ADDR_AUX_B_REF};
         unique case (state_reg)
            DSCG_IDLE, DSCG_ADDR:
            begin
               state_next = DSCG_ADDR;
               if (bitCnt_next == 5'(dscg_pkg::ADDR_W))
               begin
                  // Non-aux addresses are skipped; of those, only ADDR_GEN_RESET is decoded, from its address alone.
                  state_next = isAux ? DSCG_DATA : DSCG_SKIP;
                  if (shift_next[7:0] == dscg_pkg::ADDR_GEN_RESET)
                  begin
                     pend_next = {shift_next[7:0], 16'h0000};
                     pendValid_next = 1'b1;
                  end
               end
            end
            DSCG_DATA:
            begin
               if (bitCnt_next == 5'(dscg_pkg::FRAME_BITS))
               begin
                  pend_next = shift_next;
                  pendValid_next = 1'b1;
                  state_next = DSCG_SKIP;
               end
            end
            DSCG_SKIP:
               bitCnt_next = bitCnt_reg;
         endcase
      end
      pllA_next = pllA_reg;
      refA_next = refA_reg;
      pllB_next = pllB_reg;
      refB_next = refB_reg;
      if (apply)
      begin
         unique case (pend_reg[23:16])
            dscg_pkg::ADDR_AUX_A_PLL: pllA_next = pend_reg[15:0];
            dscg_pkg::ADDR_AUX_B_PLL: pllB_next = pend_reg[15:0];
            dscg_pkg::ADDR_AUX_A_REF: refA_next = pend_reg[15:0];
            dscg_pkg::ADDR_AUX_B_REF: refB_next = pend_reg[15:0];
            default:
            begin
               pllA_next = dscg_pkg::AUX_PLL_RESET;
               pllB_next = dscg_pkg::AUX_PLL_RESET;
               refA_next = dscg_pkg::AUX_REF_RESET;
               refB_next = dscg_pkg::AUX_REF_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= DSCG_IDLE;
         bitCnt_reg <= '0;
         shift_reg <= '0;
         pend_reg <= '0;
         pendValid_reg <= 1'b0;
         pllA_reg <= dscg_pkg::AUX_PLL_RESET;
         refA_reg <= dscg_pkg::AUX_REF_RESET;
         pllB_reg <= dscg_pkg::AUX_PLL_RESET;
         refB_reg <= dscg_pkg::AUX_REF_RESET;
      end
      else if (ce)
      begin
         state_reg <= state_next;
         bitCnt_reg <= bitCnt_next;
         shift_reg <= shift_next;
         pend_reg <= pend_next;
         pendValid_reg <= pendValid_next;
         pllA_reg <= pllA_next;
         refA_reg <= refA_next;
         pllB_reg <= pllB_next;
         refB_reg <= refB_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two independent auxiliary generators.
   dscg_pkg::dscg_aux_cfg_t cfgA, cfgB;

   always_comb
   begin
      cfgA = {refA_reg[dscg_pkg::REF_EN_BIT], refA_reg[dscg_pkg::REF_SEL_BIT],
              refA_reg[11:0], pllA_reg[10:0], pllA_reg[15:11]};
      cfgB = {refB_reg[dscg_pkg::REF_EN_BIT], refB_reg[dscg_pkg::REF_SEL_BIT],
              refB_reg[11:0], pllB_reg[10:0], pllB_reg[15:11]};
   end

   dscg_aux_clock u_auxA
   (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .oscTick(oscTick),
      .mainTick(mainTick_reg),
      .cfg(cfgA),
      .clkOut(auxClockOutA)
   );

   dscg_aux_clock u_auxB
   (
      .clock(clock),
      .arst_n(arst_n),
      .ce(ce),
      .oscTick(oscTick),
      .mainTick(mainTick_reg),
      .cfg(cfgB),
      .clkOut(auxClockOutB)
   );

   assign mainClockTick = mainTick_reg;
   assign convClockTick = conv_reg;
   assign timerTick = timer_reg;

   ////////////////////////////////////////////////////////////////////////////
   property p_idleHold;
      @(posedge clock) disable iff (!arst_n || !ce)
      pendValid_reg && idleMode && !timer_reg |=> pendValid_reg;
   endproperty
   a_idleHold: assert property (p_idleHold)
      else $error("idle write applied before timer tick");

   property p_activeApply;
      @(posedge clock) disable iff (!arst_n || !ce)
      pendValid_reg && !idleMode |=> !pendValid_reg;
   endproperty
   a_activeApply: assert property (p_activeApply)
      else $error("active write not applied at once");

   property p_pllAWrite;
      @(posedge clock) disable iff (!arst_n || !ce)
      apply && pend_reg[23:16] == dscg_pkg::ADDR_AUX_A_PLL
         |=> pllA_reg == $past(pend_reg[15:0]) && refB_reg == $past(refB_reg);
   endproperty
   a_pllAWrite: assert property (p_pllAWrite)
      else $error("divider write A lost");

   property p_genReset;
      @(posedge clock) disable iff (!arst_n || !ce)
      apply && pend_reg[23:16] == dscg_pkg::ADDR_GEN_RESET
         |=> !refA_reg[dscg_pkg::REF_EN_BIT] && !refB_reg[dscg_pkg::REF_EN_BIT];
   endproperty
   a_genReset: assert property (p_genReset)
      else $error("bus reset left an aux clock enabled");

   property p_frameLength;
      @(posedge clock) disable iff (!arst_n || !ce)
      bitCnt_reg <= 5'(dscg_pkg::FRAME_BITS);
   endproperty
   a_frameLength: assert property (p_frameLength)
      else $error("serial frame overran");

   property p_timerSpacing;
      @(posedge clock) disable iff (!arst_n || !ce)
      timer_reg |=> !timer_reg [*3];
   endproperty
   a_timerSpacing: assert property (p_timerSpacing)
      else $error("timer ticks too close");
endmodule
`default_nettype wire

/* File: test/dscg_host_model.sv */
// Host serial bus model: sends an address then a data word, MSB first.
`timescale 1ns/100ps
`default_nettype none
module dscg_host_model
(
   input wire logic clock,
   output logic busSelect_n,
   output logic busClock,
   output logic busData
);
   logic lastBit;

   initial
   begin
      busSelect_n = 1'b1;
      busClock = 1'b0;
      busData = 1'b1;
      lastBit = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Callers pass only listed addresses, with nBits of 24, or of 8 to send the address alone.
   // A half width above the minimum of 3 gives a slow host.
   task automatic send(input logic [7:0] addr, input logic [15:0] data,
                       input int nBits, input int halfW);
      logic [23:0] frame;
      frame = {addr, data};
      busSelect_n = 1'b0;
      hold(3);
      for (int i = 23; i > 23 - nBits; i--)
      begin
         busData = frame[i];
         lastBit = frame[i];
         hold(3);
         busClock = 1'b1;
         hold(halfW);
         busClock = 1'b0;
         hold(halfW);
      end
      busSelect_n = 1'b1;
      // A released data line must not keep looking valid.
      busData = ~lastBit;
      hold(4);
   endtask
endmodule
`default_nettype wire

/* File: test/dscg_top_tb.sv */
// Self-checking testbench of the system clock generation block.
`timescale 1ns/100ps
`default_nettype none
module dscg_top_tb;
   localparam int TDIV = 8;
   localparam int OSC_HALF = 4;
   logic clock, arst_n, ce, oscIn, busSelect_n, busClock, busData;
   logic idleMode, clkParamLoad;
   dscg_pkg::dscg_clk_param_t clkParamIn;
   logic mainClockTick, convClockTick, timerTick, auxClockOutA, auxClockOutB;
   int n_mismatch, checks_done, oscCnt, cyc;
   int cntA, cntB, cntMain, cntConv, t0, t1, rd, n, od, e;
   logic prevA, prevB;
   logic [31:0] rng;

   dscg_top #(.TIMER_DIV(TDIV)) DUT (.clock(clock), .arst_n(arst_n),
      .ce(ce), .oscIn(oscIn), .busSelect_n(busSelect_n),
      .busClock(busClock), .busData(busData), .idleMode(idleMode),
      .clkParamLoad(clkParamLoad), .clkParamIn(clkParamIn),
      .mainClockTick(mainClockTick), .convClockTick(convClockTick),
      .timerTick(timerTick), .auxClockOutA(auxClockOutA),
      .auxClockOutB(auxClockOutB));

   dscg_host_model host (.clock(clock), .busSelect_n(busSelect_n),
      .busClock(busClock), .busData(busData));

   initial clock = 1'b0;
   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator of 12.5MHz, inside the driven-clock limit.
   always @(negedge clock)
   begin
      cyc <= cyc + 1;
      oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
      if (oscCnt == OSC_HALF - 1)
         oscIn <= ~oscIn;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   // Expected output edges: reference / R * N / output divider.
   function automatic int exp_aux(input int sel, input int r, input int m,
                                  input int o, input int ticks);
      int ref_t;
      ref_t = sel ? ticks * 32 / 25 : ticks;
      return ref_t * m / (r * o);
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_near(input int got, input int exp, input int tol);
      checks_done++;
      if (got < exp - tol || got > exp + tol)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic measure(input int len);
      cntA = 0;
      cntB = 0;
      cntMain = 0;
      cntConv = 0;
      repeat (len)
      begin
         @(negedge clock);
         if (auxClockOutA === 1'b1 && prevA === 1'b0)
            cntA++;
         if (auxClockOutB === 1'b1 && prevB === 1'b0)
            cntB++;
         cntMain += (mainClockTick === 1'b1);
         cntConv += (convClockTick === 1'b1);
         prevA = auxClockOutA;
         prevB = auxClockOutB;
      end
   endtask

   task automatic wait_tick(output int at);
      at = 0;
      for (int i = 0; i < 5000 && at == 0; i++)
      begin
         @(negedge clock);
         if (timerTick === 1'b1)
            at = cyc;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      rng = xs(rng);
      host.send(a, d, 24, 3 + int'(rng[1:0] % 2'd2));
   endtask

   initial
   begin
      repeat (60000) @(posedge clock);
      n_mismatch++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rng = 32'h0000C238;
      n_mismatch = 0;
      checks_done = 0;
      oscCnt = 0;
      cyc = 0;
      oscIn = 1'b0;
      arst_n = 1'b0;
      ce = 1'b1;
      idleMode = 1'b0;
      clkParamLoad = 1'b0;
      clkParamIn = '0;
      prevA = 1'b0;
      prevB = 1'b0;
      repeat (6) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
      measure(800);
      chk_eq(cntA, 0);
      chk_eq(cntB, 0);
      chk_near(cntMain, 128, 2);
      chk_near(cntConv, 43, 1);
      wait_tick(t0);
      wait_tick(t1);
      chk_eq(t1 - t0, TDIV * 2 * OSC_HALF);
      // Each clock, from each reference source, with random dividers.
      for (int k = 0; k < 4; k++)
      begin
         rng = xs(rng);
         rd = 1 + rng[1:0];
         n = 1 + rng[3:2];
         od = 2 + rng[5:4];
         wr(k[0] ? dscg_pkg::ADDR_AUX_B_PLL : dscg_pkg::ADDR_AUX_A_PLL,
            {5'(od), 11'(n)});
         // Small R keeps each loop reference near its design rate.
         wr(k[0] ? dscg_pkg::ADDR_AUX_B_REF : dscg_pkg::ADDR_AUX_A_REF,
            {1'b1, k[1], 2'b00, 12'(rd)});
         repeat (20) @(negedge clock);
         measure(2400);
         e = exp_aux(k[1], rd, n, od, 300);
         chk_near(k[0] ? cntB : cntA, e, 3);
      end
      // Powersave of A alone leaves B running.
      wr(dscg_pkg::ADDR_AUX_A_REF, 16'h0001);
      repeat (10) @(negedge clock);
      measure(1200);
      chk_eq(cntA, 0);
      chk_eq({31'b0, auxClockOutA}, 32'h00000000);
      chk_near(cntB, e / 2, 3);
      host.send(dscg_pkg::ADDR_GEN_RESET, 16'h0000, 8, 3);
      repeat (10) @(negedge clock);
      measure(800);
      chk_eq(cntB, 0);
      chk_eq({31'b0, auxClockOutB}, 32'h00000000);
      // Host loads a longer timer divide at initialisation.
      clkParamIn.mainMul = dscg_pkg::MAIN_MUL_DFLT;
      clkParamIn.mainDiv = dscg_pkg::MAIN_DIV_DFLT;
      clkParamIn.convDiv = dscg_pkg::CONV_DIV_DFLT;
      clkParamIn.timerDiv = 16'h0040;
      clkParamLoad = 1'b1;
      @(negedge clock);
      clkParamLoad = 1'b0;
      wait_tick(t0);
      wait_tick(t1);
      chk_eq(t1 - t0, 64 * 2 * OSC_HALF);
      // In idle a write waits for the next timer tick.
      wr(dscg_pkg::ADDR_AUX_B_PLL, 16'h1001);
      idleMode = 1'b1;
      wait_tick(t0);
      wr(dscg_pkg::ADDR_AUX_B_REF, 16'h8001);
      measure(150);
      chk_eq(cntB, 0);
      wait_tick(t1);
      chk_eq(t1 - t0, 64 * 2 * OSC_HALF);
      measure(800);
      chk_near(cntB, exp_aux(0, 1, 1, 2, 100), 2);
      // A low clock enable freezes every counter and output.
      while (mainClockTick !== 1'b0)
         @(negedge clock);
      ce = 1'b0;
      measure(100);
      ce = 1'b1;
      chk_eq(cntMain, 0);
      chk_eq(cntB, 0);
      end_sim();
   end
endmodule
`default_nettype wire
